// [tmx_test_mux.sv]
// Test bus multiplexer with mode register and readback
// Notes on behaviour
// - Eight-bit test bus carries the selected internal signals or values.
// - A separate strobe output accompanies the bus for sampling it.
// - Software writes the mode register; the matching group goes to the bus.
// - The byte on the bus is readable from the readback register.
// - Twenty-two mode codes are decoded, each with its content and a strobe, except mode 15 whose strobe is held low and modes 25-27 that put a data bit there.
// - Factory codes 11,19,20,22-24,28 have no user behaviour; bus reads zero.
// - Mode 1 shows receive acquisition flags, initial detect as strobe.
// - Mode 2 shows transmit field starts, iq marker as strobe.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "tmx_defines.svh"
module tmx_test_mux
  import tmx_pkg::*;
(
  // Core clock and register port
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Sample clock domain
  input  wire logic        sample_clk,
  input  wire logic        link_rst_n,
  // Receive acquisition flags
  input  wire logic        initial_detect,
  input  wire logic        converter_calibration_clock,
  input  wire logic        carrier_sense_flag,
  input  wire logic        energy_detect_flag,
  input  wire logic        track,
  input  wire logic        sfd_detect,
  input  wire logic        signal_field_ready,
  input  wire logic        length_field_ready,
  input  wire logic        header_check_valid,
  // Transmit field markers
  input  wire logic        iq_marker_strobe,
  input  wire logic        internal_transmit_enable,
  input  wire logic        preamble_start,
  input  wire logic        sfd_start,
  input  wire logic        signal_start,
  input  wire logic        length_start,
  input  wire logic        crc_start,
  input  wire logic        payload_start,
  // Monitored values
  input  wire logic        rssi_pulse,
  input  wire logic        cse_latched,
  input  wire logic        cse,
  input  wire logic [5:0]  rssi_value,
  input  wire logic        sq_valid_pulse,
  input  wire logic [7:0]  sq1_value,
  input  wire logic [15:0] sq2_value,
  input  wire logic        subsample_mark,
  input  wire logic [7:0]  correlator_mag,
  input  wire logic [18:0] freq_reg,
  input  wire logic [7:0]  phase_reg,
  input  wire logic [15:0] nco_reg,
  input  wire logic [7:0]  bit_sync_accum,
  input  wire logic        adcal_clk,
  input  wire logic        adcal_disable,
  input  wire logic [4:0]  adcal_value,
  input  wire logic [8:0]  corr_i,
  input  wire logic [8:0]  corr_q,
  input  wire logic [14:0] chip_err_accum,
  input  wire logic [19:0] nco_accum,
  input  wire logic [18:0] lag_accum,
  input  wire logic [6:0]  carrier_phase_err,
  input  wire logic [2:0]  i_adc,
  input  wire logic [2:0]  q_adc,
  input  wire logic [23:0] adcal_accum,
  input  wire logic [15:0] freq_accum,
  // Test port
  output logic      [7:0]  test_bus,
  output logic             test_bus_strobe
);

  // Core domain state
  tmx_mode_t test_mode_select_reg, next_test_mode_select_reg;
  tmx_mode_t mode_hold, next_mode_hold;
  tmx_byte_t test_bus_readback_reg, next_test_bus_readback_reg;
  tmx_byte_t next_reg_rdata;
  logic      mode_req, next_mode_req;
  logic      rb_req, next_rb_req;
  logic      mode_ack_s1, mode_ack_s2;
  logic      rb_ack_s1, rb_ack_s2;

  // Sample domain state
  tmx_mode_t mode_s, next_mode_s;
  tmx_byte_t snap, next_snap;
  tmx_byte_t next_test_bus;
  logic      next_test_bus_strobe;
  logic      mode_ack, next_mode_ack;
  logic      rb_ack, next_rb_ack;
  logic      sample_phase;
  logic      mode_req_s1, mode_req_s2;
  logic      rb_req_s1, rb_req_s2;

  always_comb
  begin
    next_test_mode_select_reg  = test_mode_select_reg;
    next_mode_hold             = mode_hold;
    next_mode_req              = mode_req;
    next_rb_req                = rb_req;
    next_test_bus_readback_reg = test_bus_readback_reg;
    next_reg_rdata             = `TMX_BYTE_RST;
    if (reg_wr && reg_addr == `TMX_ADDR_MODE)
      next_test_mode_select_reg = reg_wdata[4:0];
    if (mode_req == mode_ack_s2 && mode_hold != test_mode_select_reg)
    begin
      next_mode_hold = test_mode_select_reg;
      next_mode_req  = ~mode_req;
    end
    if (rb_req == rb_ack_s2)
    begin
      next_test_bus_readback_reg = snap;
      next_rb_req                = ~rb_req;
    end
    if (reg_rd && reg_addr == `TMX_ADDR_MODE)
      next_reg_rdata = {3'h0, test_mode_select_reg};
    else if (reg_rd && reg_addr == `TMX_ADDR_READBACK)
      next_reg_rdata = test_bus_readback_reg;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      test_mode_select_reg  <= `TMX_MODE_RST;
      mode_hold             <= `TMX_MODE_RST;
      mode_req              <= 1'b0;
      rb_req                <= 1'b0;
      test_bus_readback_reg <= `TMX_BYTE_RST;
      reg_rdata             <= `TMX_BYTE_RST;
      mode_ack_s1           <= 1'b0;
      mode_ack_s2           <= 1'b0;
      rb_ack_s1             <= 1'b0;
      rb_ack_s2             <= 1'b0;
    end
    else
    begin
      test_mode_select_reg  <= next_test_mode_select_reg;
      mode_hold             <= next_mode_hold;
      mode_req              <= next_mode_req;
      rb_req                <= next_rb_req;
      test_bus_readback_reg <= next_test_bus_readback_reg;
      reg_rdata             <= next_reg_rdata;
      mode_ack_s1           <= mode_ack;
      mode_ack_s2           <= mode_ack_s1;
      rb_ack_s1             <= rb_ack;
      rb_ack_s2             <= rb_ack_s1;
    end
  end

  // Mode decode onto the test port
  always_comb
  begin
    next_mode_s          = mode_s;
    next_mode_ack        = mode_ack;
    next_snap            = snap;
    next_rb_ack          = rb_ack;
    next_test_bus        = `TMX_BYTE_RST;
    next_test_bus_strobe = 1'b0;
    if (mode_req_s2 != mode_ack)
    begin
      next_mode_s   = mode_hold;
      next_mode_ack = mode_req_s2;
    end
    if (rb_req_s2 != rb_ack)
    begin
      next_snap   = test_bus;
      next_rb_ack = rb_req_s2;
    end
    unique case (mode_s)
      `TMX_MODE_RX_ACQ:
        {next_test_bus_strobe, next_test_bus} = {initial_detect, converter_calibration_clock,
          carrier_sense_flag, energy_detect_flag, track, sfd_detect, signal_field_ready,
          length_field_ready, header_check_valid};
      `TMX_MODE_TX_FIELD:
        {next_test_bus_strobe, next_test_bus} = {iq_marker_strobe, converter_calibration_clock,
          internal_transmit_enable, preamble_start, sfd_start, signal_start, length_start,
          crc_start, payload_start};
      `TMX_MODE_RSSI:
        {next_test_bus_strobe, next_test_bus} = {rssi_pulse, cse_latched, cse, rssi_value};
      `TMX_MODE_SQ1:
        {next_test_bus_strobe, next_test_bus} = {sq_valid_pulse, sq1_value};
      `TMX_MODE_SQ2:
        {next_test_bus_strobe, next_test_bus} = {sq_valid_pulse, sq2_value[7:0]};
      `TMX_MODE_CORR_MAG:
        {next_test_bus_strobe, next_test_bus} = {sample_phase, correlator_mag};
      `TMX_MODE_FREQ_LO:
        {next_test_bus_strobe, next_test_bus} = {subsample_mark, freq_reg[18:11]};
      `TMX_MODE_PHASE_LO:
        {next_test_bus_strobe, next_test_bus} = {subsample_mark, phase_reg};
      `TMX_MODE_NCO_LO:
        {next_test_bus_strobe, next_test_bus} = {subsample_mark, nco_reg[15:8]};
      `TMX_MODE_BSYNC_LO:
        {next_test_bus_strobe, next_test_bus} = {sample_phase, bit_sync_accum};
      `TMX_MODE_ADCAL:
        {next_test_bus_strobe, next_test_bus} = {adcal_clk, converter_calibration_clock,
          energy_detect_flag, adcal_disable, adcal_value};
      `TMX_MODE_CORR_I:
        {next_test_bus_strobe, next_test_bus} = {sample_phase, corr_i[8:1]};
      `TMX_MODE_CORR_Q:
        {next_test_bus_strobe, next_test_bus} = {sample_phase, corr_q[8:1]};
      `TMX_MODE_CHIP_ERR:
        {next_test_bus_strobe, next_test_bus} = {1'b0, chip_err_accum[14:7]};
      `TMX_MODE_NCO_HI:
        {next_test_bus_strobe, next_test_bus} = {sample_phase, nco_accum[19:12]};
      `TMX_MODE_LAG_HI:
        {next_test_bus_strobe, next_test_bus} = {sample_phase, lag_accum[18:11]};
      `TMX_MODE_CPE_HI:
        {next_test_bus_strobe, next_test_bus} = {sample_phase, carrier_phase_err[6],
          carrier_phase_err};
      `TMX_MODE_ADC_RAW:
        {next_test_bus_strobe, next_test_bus} = {sample_phase, 2'h0, i_adc, q_adc};
      `TMX_MODE_ACAL_LO:
        {next_test_bus_strobe, next_test_bus} = adcal_accum[8:0];
      `TMX_MODE_ACAL_HI:
        {next_test_bus_strobe, next_test_bus} = adcal_accum[17:9];
      `TMX_MODE_FACC_LO:
        {next_test_bus_strobe, next_test_bus} = freq_accum[15:7];
      `TMX_MODE_SQ2_HI:
        {next_test_bus_strobe, next_test_bus} = {sq_valid_pulse, sq2_value[15:8]};
      default:
        {next_test_bus_strobe, next_test_bus} = 9'h000;
    endcase
  end

  always_ff @(posedge sample_clk)
  begin
    if (!link_rst_n)
    begin
      mode_s          <= `TMX_MODE_RST;
      mode_ack        <= 1'b0;
      snap            <= `TMX_BYTE_RST;
      rb_ack          <= 1'b0;
      test_bus        <= `TMX_BYTE_RST;
      test_bus_strobe <= 1'b0;
      sample_phase    <= 1'b0;
      mode_req_s1     <= 1'b0;
      mode_req_s2     <= 1'b0;
      rb_req_s1       <= 1'b0;
      rb_req_s2       <= 1'b0;
    end
    else
    begin
      mode_s          <= next_mode_s;
      mode_ack        <= next_mode_ack;
      snap            <= next_snap;
      rb_ack          <= next_rb_ack;
      test_bus        <= next_test_bus;
      test_bus_strobe <= next_test_bus_strobe;
      sample_phase    <= ~sample_phase;
      mode_req_s1     <= mode_req;
      mode_req_s2     <= mode_req_s1;
      rb_req_s1       <= rb_req;
      rb_req_s2       <= rb_req_s1;
    end
  end

  // Checks in the sample domain
  property p_quiet;
    @(posedge sample_clk) disable iff (!link_rst_n)
    $past(mode_s) == `TMX_MODE_QUIET |-> test_bus == 8'h00 && !test_bus_strobe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet mode bus not zero");
  property p_rx_acq;
    @(posedge sample_clk) disable iff (!link_rst_n)
    mode_s == `TMX_MODE_RX_ACQ |=> test_bus_strobe == $past(initial_detect)
      && test_bus[6] == $past(carrier_sense_flag) && test_bus[0] == $past(header_check_valid);
  endproperty
  a_rx_acq: assert property (p_rx_acq) else $error("rx acquisition bits wrong");
  property p_tx_field;
    @(posedge sample_clk) disable iff (!link_rst_n)
    mode_s == `TMX_MODE_TX_FIELD |=> test_bus_strobe == $past(iq_marker_strobe)
      && test_bus[6] == $past(internal_transmit_enable) && test_bus[0] == $past(payload_start);
  endproperty
  a_tx_field: assert property (p_tx_field) else $error("tx field bits wrong");
  property p_reserved;
    @(posedge sample_clk) disable iff (!link_rst_n)
    (mode_s == `TMX_MODE_RSV_11 || mode_s == `TMX_MODE_RSV_28) |=> test_bus == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode drives bus");
  property p_freq_slice;
    @(posedge sample_clk) disable iff (!link_rst_n)
    mode_s == `TMX_MODE_FREQ_LO |=> test_bus == $past(freq_reg[18:11]);
  endproperty
  a_freq_slice: assert property (p_freq_slice) else $error("freq slice wrong");
  property p_acal_hi;
    @(posedge sample_clk) disable iff (!link_rst_n)
    mode_s == `TMX_MODE_ACAL_HI |=> test_bus_strobe == $past(adcal_accum[17])
      && test_bus == $past(adcal_accum[16:9]);
  endproperty
  a_acal_hi: assert property (p_acal_hi) else $error("cal accum hi wrong");
  property p_sq2_hi_strobe;
    @(posedge sample_clk) disable iff (!link_rst_n)
    mode_s == `TMX_MODE_SQ2_HI && sq_valid_pulse |=> test_bus_strobe;
  endproperty
  a_sq2_hi_strobe: assert property (p_sq2_hi_strobe) else $error("sq strobe lost");

  // Checks in the core domain
  property p_mode_write;
    @(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == `TMX_ADDR_MODE |=> test_mode_select_reg == $past(reg_wdata[4:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_mode_read;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `TMX_ADDR_MODE |=> reg_rdata == {3'h0, $past(test_mode_select_reg)};
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");

  property p_readback_loop;
    @(posedge core_clk) disable iff (!rst_n)
    rb_req != rb_ack_s2 |-> ##[1:20] rb_req == rb_ack_s2;
  endproperty
  a_readback_loop: assert property (p_readback_loop) else $error("readback stalled");

  property p_readback_read;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `TMX_ADDR_READBACK |=> reg_rdata == $past(test_bus_readback_reg);
  endproperty
  a_readback_read: assert property (p_readback_read) else $error("readback read wrong");

  c_rx_acq: cover property (@(posedge sample_clk) mode_s == `TMX_MODE_RX_ACQ ##1 test_bus_strobe);
  c_tx_field: cover property (@(posedge sample_clk) mode_s == `TMX_MODE_TX_FIELD ##1 test_bus != 0);
  c_mode_write: cover property (@(posedge core_clk) reg_wr && reg_addr == `TMX_ADDR_MODE);
  c_readback: cover property (@(posedge core_clk) reg_rd && reg_addr == `TMX_ADDR_READBACK);

endmodule

// [tmx_defines.svh]
// Offsets, reset values and mode codes of the test bus multiplexer
`ifndef TMX_DEFINES_SVH
`define TMX_DEFINES_SVH
`define TMX_ADDR_MODE      6'h1C
`define TMX_ADDR_READBACK  6'h1D
`define TMX_MODE_RST       5'h00
`define TMX_MODE_QUIET     5'h00
`define TMX_MODE_RX_ACQ    5'h01
`define TMX_MODE_TX_FIELD  5'h02
`define TMX_MODE_RSSI      5'h03
`define TMX_MODE_SQ1       5'h04
`define TMX_MODE_SQ2       5'h05
`define TMX_MODE_CORR_MAG  5'h06
`define TMX_MODE_FREQ_LO   5'h07
`define TMX_MODE_PHASE_LO  5'h08
`define TMX_MODE_NCO_LO    5'h09
`define TMX_MODE_BSYNC_LO  5'h0A
`define TMX_MODE_ADCAL     5'h0C
`define TMX_MODE_CORR_I    5'h0D
`define TMX_MODE_CORR_Q    5'h0E
`define TMX_MODE_CHIP_ERR  5'h0F
`define TMX_MODE_NCO_HI    5'h10
`define TMX_MODE_LAG_HI    5'h11
`define TMX_MODE_CPE_HI    5'h12
`define TMX_MODE_ADC_RAW   5'h15
`define TMX_MODE_ACAL_LO   5'h19
`define TMX_MODE_ACAL_HI   5'h1A
`define TMX_MODE_FACC_LO   5'h1B
`define TMX_MODE_SQ2_HI    5'h1D
`define TMX_MODE_RSV_11    5'h0B
`define TMX_MODE_RSV_28    5'h1C
`define TMX_BYTE_RST       8'h00
`endif

// [tmx_pkg.sv]
// Types shared by the test bus multiplexer
package tmx_pkg;
  typedef logic [4:0] tmx_mode_t;
  typedef logic [7:0] tmx_byte_t;
endpackage

// [tmx_field_source.sv]
// Far-side model driving the monitored internal signals from one pattern byte
`timescale 1ns/1ps
module tmx_field_source
  import tmx_pkg::*;
(
  // Clock and pattern
  input  wire logic  sample_clk,
  input  wire tmx_byte_t pat,
  // Acquisition flags and transmit markers
  output logic initial_detect, converter_calibration_clock, carrier_sense_flag,
  output logic energy_detect_flag, track, sfd_detect, signal_field_ready,
  output logic length_field_ready, header_check_valid, iq_marker_strobe,
  output logic internal_transmit_enable, preamble_start, sfd_start, signal_start,
  output logic length_start, crc_start, payload_start,
  // Monitored values
  output logic rssi_pulse, cse_latched, cse, sq_valid_pulse, subsample_mark,
  output logic adcal_clk, adcal_disable,
  output logic [5:0]  rssi_value,
  output logic [7:0]  sq1_value, correlator_mag, phase_reg, bit_sync_accum,
  output logic [15:0] sq2_value, nco_reg, freq_accum,
  output logic [18:0] freq_reg, lag_accum,
  output logic [4:0]  adcal_value,
  output logic [8:0]  corr_i, corr_q,
  output logic [14:0] chip_err_accum,
  output logic [19:0] nco_accum,
  output logic [6:0]  carrier_phase_err,
  output logic [2:0]  i_adc, q_adc,
  output logic [23:0] adcal_accum
);
  logic [31:0] rep;
  assign rep = {4{pat}};
  // Every field is a slice, inversion or parity of the repeated pattern, so any slice is predictable
  always_ff @(posedge sample_clk)
  begin
    {converter_calibration_clock, carrier_sense_flag, energy_detect_flag, track, sfd_detect,
     signal_field_ready, length_field_ready, header_check_valid} <= pat;
    initial_detect <= ^pat;
    iq_marker_strobe <= ~^pat;
    {internal_transmit_enable, preamble_start, sfd_start, signal_start, length_start,
     crc_start, payload_start} <= ~pat[6:0];
    {cse_latched, cse, rssi_value} <= ~pat;
    {rssi_pulse, sq_valid_pulse, subsample_mark, adcal_clk} <= {pat[2], pat[3], pat[4], pat[6]};
    {adcal_disable, adcal_value} <= pat[5:0];
    {i_adc, q_adc} <= pat[5:0];
    carrier_phase_err <= pat[6:0];
    sq1_value <= pat;
    correlator_mag <= pat;
    phase_reg <= pat;
    bit_sync_accum <= pat;
    sq2_value <= rep[15:0];
    nco_reg <= rep[15:0];
    freq_accum <= rep[15:0];
    freq_reg <= rep[18:0];
    lag_accum <= rep[18:0];
    corr_i <= rep[8:0];
    corr_q <= rep[8:0];
    chip_err_accum <= rep[14:0];
    nco_accum <= rep[19:0];
    adcal_accum <= rep[23:0];
  end
endmodule

// [test_tmx_test_mux.sv]
// Testbench for the test bus multiplexer
`timescale 1ns/1ps
`include "tmx_defines.svh"
module test_tmx_test_mux
  import tmx_pkg::*;
;
  logic core_clk, rst_n, reg_wr, reg_rd, sample_clk, link_rst_n, test_bus_strobe;
  logic [5:0] reg_addr;
  tmx_byte_t reg_wdata, reg_rdata, test_bus, pat, v;
  logic initial_detect, converter_calibration_clock, carrier_sense_flag, energy_detect_flag;
  logic track, sfd_detect, signal_field_ready, length_field_ready, header_check_valid;
  logic iq_marker_strobe, internal_transmit_enable, preamble_start, sfd_start, signal_start;
  logic length_start, crc_start, payload_start, rssi_pulse, cse_latched, cse, sq_valid_pulse;
  logic subsample_mark, adcal_clk, adcal_disable;
  logic [5:0]  rssi_value;
  logic [7:0]  sq1_value, correlator_mag, phase_reg, bit_sync_accum;
  logic [15:0] sq2_value, nco_reg, freq_accum;
  logic [18:0] freq_reg, lag_accum;
  logic [4:0]  adcal_value;
  logic [8:0]  corr_i, corr_q;
  logic [14:0] chip_err_accum;
  logic [19:0] nco_accum;
  logic [6:0]  carrier_phase_err;
  logic [2:0]  i_adc, q_adc;
  logic [23:0] adcal_accum;
  int          bad_count = 0;
  int          check_count = 0;

  tmx_test_mux i_tmx_test_mux (.*);
  tmx_field_source i_tmx_field_source (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    sample_clk = 1'b0;
    #3;
    forever #16 sample_clk = ~sample_clk;
  end

  initial
  begin
    link_rst_n = 1'b0;
    repeat (3) @(posedge sample_clk);
    link_rst_n <= 1'b1;
  end

  task automatic chk(input tmx_byte_t seen, input tmx_byte_t exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input tmx_byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output tmx_byte_t d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask

  // Select a mode, present a pattern and let both crossings settle
  task automatic apply(input tmx_mode_t m, input tmx_byte_t p);
    wr(`TMX_ADDR_MODE, {3'b000, m});
    pat <= p;
    repeat (20) @(posedge sample_clk);
    @(posedge core_clk);
  endtask

  function automatic tmx_byte_t exp_bus(input tmx_mode_t m, input tmx_byte_t p);
    logic [31:0] r;
    r = {4{p}};
    case (m)
      5'h01, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0A, 5'h19: return p;
      5'h02: return {p[7], ~p[6:0]};
      5'h03: return ~p;
      5'h07, 5'h11: return r[18:11];
      5'h09, 5'h1D: return r[15:8];
      5'h0C: return {p[7], p[5], p[5:0]};
      5'h0D, 5'h0E: return r[8:1];
      5'h0F, 5'h1B: return r[14:7];
      5'h10: return r[19:12];
      5'h12: return {p[6], p[6:0]};
      5'h15: return {2'b00, p[5:0]};
      5'h1A: return r[16:9];
      default: return 8'h00;
    endcase
  endfunction

  // Upper bit says whether the strobe is a predictable level in this mode
  function automatic logic [1:0] exp_strobe(input tmx_mode_t m, input tmx_byte_t p);
    case (m)
      5'h01: return {1'b1, ^p};
      5'h02: return {1'b1, ~^p};
      5'h03: return {1'b1, p[2]};
      5'h04, 5'h05, 5'h1D: return {1'b1, p[3]};
      5'h07, 5'h08, 5'h09: return {1'b1, p[4]};
      5'h0C: return {1'b1, p[6]};
      5'h19: return {1'b1, p[0]};
      5'h1A: return {1'b1, p[1]};
      5'h1B: return {1'b1, p[7]};
      5'h06, 5'h0A, 5'h0D, 5'h0E, 5'h10, 5'h11, 5'h12, 5'h15: return 2'b00;
      default: return 2'b10;
    endcase
  endfunction

  task automatic conclude;
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #200000;
    bad_count++;
    conclude;
  end

  initial
  begin
    tmx_mode_t   m;
    logic [1:0]  s;
    rst_n = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pat = 8'h00;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(`TMX_ADDR_MODE, v);
    chk(v, 8'h00);
    rd(`TMX_ADDR_READBACK, v);
    chk(v, 8'h00);
    chk(test_bus, 8'h00);
    wr(`TMX_ADDR_MODE, 8'hE5);
    rd(`TMX_ADDR_MODE, v);
    chk(v, 8'h05);
    rd(6'h00, v);
    chk(v, 8'h00);
    apply(5'h04, 8'hFF);
    chk(test_bus, 8'hFF);
    apply(5'h01, 8'h5A);
    chk(test_bus, 8'h5A);
    chk({7'h00, test_bus_strobe}, 8'h00);
    apply(5'h02, 8'h5A);
    chk(test_bus, 8'h25);
    chk({7'h00, test_bus_strobe}, 8'h01);
    wr(`TMX_ADDR_READBACK, 8'hFF);
    rd(`TMX_ADDR_READBACK, v);
    chk(v, 8'h25);
    apply(5'h1C, 8'hFF);
    chk(test_bus, 8'h00);
    apply(5'h00, 8'hFF);
    chk(test_bus, 8'h00);
    chk({7'h00, test_bus_strobe}, 8'h00);
    for (int i = 0; i < 64; i++)
    begin
      m = i[4:0];
      apply(m, i[5] ? 8'h3C : 8'hA5);
      chk(test_bus, exp_bus(m, pat));
      s = exp_strobe(m, pat);
      if (s[1]) chk({7'h00, test_bus_strobe}, {7'h00, s[0]});
      else
      begin
        @(posedge sample_clk);
        #1 v = {7'h00, test_bus_strobe};
        @(posedge sample_clk);
        #1 chk({7'h00, test_bus_strobe}, {7'h00, ~v[0]});
        @(posedge core_clk);
      end
      rd(`TMX_ADDR_READBACK, v);
      chk(v, exp_bus(m, pat));
      rd(`TMX_ADDR_MODE, v);
      chk(v, {3'b000, m});
    end
    conclude;
  end
endmodule
